// >>> pkg/smt_map.vh
// Register offsets, field positions, reset values and mode codes of the
// signal measurement timer. Assumes a 32-bit AXI4-Lite register window.
`ifndef SMT_MAP_VH
`define SMT_MAP_VH
`define OFF_CON0        8'h00
`define OFF_CON1        8'h04
`define OFF_STAT        8'h08
`define OFF_CLKSEL      8'h0C
`define OFF_COUNTER     8'h10
`define OFF_WIDTH       8'h14
`define OFF_PERIOD      8'h18
`define OFF_MATCH       8'h1C
`define CON0_PRESCALE   1:0
`define CON0_CLOCK_POLARITY       2
`define CON0_SIGNAL_POLARITY       3
`define CON0_WINDOW_POLARITY       4
`define CON0_HALT       5
`define CON0_NARROW     6
`define CON1_MODE       3:0
`define CON1_REPEAT     6
`define CON1_RUN        7
`define STAT_WIDTH_UPD  0
`define STAT_PERIOD_UPD 1
`define STAT_CLEAR      2
`define STAT_WIN_LVL    3
`define STAT_SIG_LVL    4
`define STAT_RUNNING    5
`define STAT_WIDTH_FLG  8
`define STAT_PERIOD_FLG 9
`define STAT_MATCH_FLG  10
`define CON0_RESET      8'h00
`define CON1_RESET      8'h00
`define CLKSEL_RESET    3'h0
`define MATCH_RESET     24'hFFFFFF
`define MODE_TIMER      4'h0
`define MODE_GATED      4'h1
`define MODE_DUTY       4'h2
`define MODE_HILO       4'h3
`define MODE_WINDOW     4'h4
`define MODE_GATEWIN    4'h5
`define MODE_FLIGHT     4'h6
`define MODE_CAPTURE    4'h7
`define MODE_COUNT      4'h8
`define MODE_GCOUNT     4'h9
`define MODE_WCOUNT     4'hA
`define SRC_SYS         3'h0
`define SRC_SYS_DIV4    3'h1
`define SRC_FAST        3'h2
`define SRC_SLOW        3'h3
`define SRC_MID         3'h4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// >>> core/clock_front.v
// Clock source selection and prescaler producing a one-cycle tick.
// Assumes oscillator pins are asynchronous to mclk and slower than mclk/2.
`timescale 1ns/100ps
`include "smt_map.vh"
module clock_front (
	input  wire       mclk,
	input  wire       resetn,
	input  wire       fast_internal_oscillator,
	input  wire       slow_internal_oscillator,
	input  wire       mid_internal_oscillator,
	input  wire [2:0] clock_source_select,
	input  wire [1:0] prescale_select,
	input  wire       clock_polarity,
	output reg        clock_tick
);
	wire [2:0] osc_pin;
	reg  [2:0] sync1_reg;
	reg  [2:0] sync2_reg;
	reg  [2:0] last_reg;
	wire [2:0] osc_edge;
	reg  [1:0] div4_reg;
	reg  [2:0] pre_reg;
	reg        raw_tick;
	wire [2:0] pre_mask;

	assign osc_pin = {mid_internal_oscillator, slow_internal_oscillator,
		fast_internal_oscillator};
	assign pre_mask = (3'h1 << prescale_select) - 3'h1;

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : osc_sync
			always @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
					last_reg[i]  <= 1'b0;
				end else begin
					sync1_reg[i] <= osc_pin[i];
					sync2_reg[i] <= sync1_reg[i];
					last_reg[i]  <= sync2_reg[i];
				end
			end
			// Inverted polarity counts falling edges instead.
			assign osc_edge[i] = clock_polarity ?
				(last_reg[i] & ~sync2_reg[i]) : (sync2_reg[i] & ~last_reg[i]);
		end
	endgenerate

	always @* begin
		case (clock_source_select)
		`SRC_SYS:      raw_tick = 1'b1;
		`SRC_SYS_DIV4: raw_tick = (div4_reg == 2'h3);
		`SRC_FAST:     raw_tick = osc_edge[0];
		`SRC_SLOW:     raw_tick = osc_edge[1];
		`SRC_MID:      raw_tick = osc_edge[2];
		default:       raw_tick = 1'b0;
		endcase
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div4_reg   <= 2'h0;
			pre_reg    <= 3'h0;
			clock_tick <= 1'b0;
		end else begin
			div4_reg   <= div4_reg + 2'h1;
			clock_tick <= 1'b0;
			if (raw_tick) begin
				// Divide by 1, 2, 4 or 8 selected source edges.
				pre_reg    <= pre_reg + 3'h1;
				clock_tick <= ((pre_reg & pre_mask) == pre_mask);
			end
		end
	end
endmodule // clock_front

// >>> core/measure_timer.v
// Signal measurement timer with an AXI4-Lite register slave.
// Assumes signal, window and oscillator inputs are asynchronous pins.
`timescale 1ns/100ps
`include "smt_map.vh"
// Functional notes
// - 24-bit counter, byte writable, optional 16-bit width.
// - Three-bit select picks one of five clocks.
// - Prescaled clock drives counter and input sampling, except in counter modes.
// - Counter equal to match value rolls, flags.
// - Clear bit zeroes the whole counter.
// - Width latch captures on mode trigger or request.
// - Period latch captures on mode trigger or request.
// - Halt blocks rollover; match flag keeps setting.
// - Polarity bits invert window, signal and clock.
// - Window level shown in window, gated-window and gated-count modes while running.
// - Signal level shown in most modes while running.
// - Run state follows run request after sampling.
// - Single acquisition stops and clears run request.
// - Four-bit mode field; high codes reserved.
// - Timer mode counts freely, ignores input events.
// - Gated timer counts while signal active.
// - Duty mode: falls to width, rises to period.
// - High-low mode resets counter at each capture.
// - Latch updates set sticky acquisition flags.
module measure_timer (
	input  wire        mclk,
	input  wire        resetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        measured_input,
	input  wire        window_input,
	input  wire        fast_internal_oscillator,
	input  wire        slow_internal_oscillator,
	input  wire        mid_internal_oscillator
);
	reg  [7:0]  control_register_zero;
	reg  [7:0]  control_register_one;
	reg  [2:0]  clock_select_register;
	reg  [23:0] measure_counter;
	reg  [23:0] pulse_width_latch;
	reg  [23:0] period_latch;
	reg  [23:0] period_match_value;
	reg         run_state;
	reg         width_acquired_flag;
	reg         period_acquired_flag;
	reg         match_flag;
	reg         armed_reg;
	reg         seen_fall_reg;
	reg  [7:0]  awaddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	reg         aw_held;
	reg         w_held;
	reg  [1:0]  sig_sync;
	reg  [1:0]  win_sync;
	reg         sig_cur;
	reg         win_cur;
	wire        clock_tick;
	wire [3:0]  mode;
	wire        sig_pol;
	wire        win_pol;
	wire        step;
	wire        active;
	wire        s_rise;
	wire        s_fall;
	wire        w_rise;
	wire        w_fall;
	wire        narrow;
	wire        at_match;
	wire [23:0] count_plus;
	wire        wr_fire;
	wire        wr_stat;
	wire        window_level;
	wire        signal_level;
	wire [31:0] stat_word;
	reg         do_inc;
	reg         do_zero;
	reg         do_one;
	reg         cap_width;
	reg         cap_period;
	reg         done;
	reg         arm_set;
	reg         arm_clr;
	reg  [31:0] read_word;
	reg  [1:0]  read_resp;

	function [23:0] merge24;
		input [23:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge24[7:0]   = strb[0] ? data[7:0] : old[7:0];
			merge24[15:8]  = strb[1] ? data[15:8] : old[15:8];
			merge24[23:16] = strb[2] ? data[23:16] : old[23:16];
		end
	endfunction

	function is_counter_mode;
		input [3:0] m;
		begin
			is_counter_mode = (m == `MODE_COUNT) || (m == `MODE_GCOUNT) ||
				(m == `MODE_WCOUNT);
		end
	endfunction

	clock_front u_clock_front (
		.mclk                     (mclk),
		.resetn                   (resetn),
		.fast_internal_oscillator (fast_internal_oscillator),
		.slow_internal_oscillator (slow_internal_oscillator),
		.mid_internal_oscillator  (mid_internal_oscillator),
		.clock_source_select      (clock_select_register),
		.prescale_select          (control_register_zero[`CON0_PRESCALE]),
		.clock_polarity           (control_register_zero[`CON0_CLOCK_POLARITY]),
		.clock_tick               (clock_tick)
	);

	assign mode    = control_register_one[`CON1_MODE];
	assign narrow  = control_register_zero[`CON0_NARROW];
	assign sig_pol = sig_sync[1] ^ control_register_zero[`CON0_SIGNAL_POLARITY];
	assign win_pol = win_sync[1] ^ control_register_zero[`CON0_WINDOW_POLARITY];
	// Counter modes follow the signal itself, not the prescaled clock.
	assign step    = is_counter_mode(mode) | clock_tick;
	assign active  = run_state & control_register_one[`CON1_RUN];
	assign s_rise  = step & sig_pol & ~sig_cur;
	assign s_fall  = step & ~sig_pol & sig_cur;
	assign w_rise  = step & win_pol & ~win_cur;
	assign w_fall  = step & ~win_pol & win_cur;
	assign at_match = narrow ?
		(measure_counter[15:0] == period_match_value[15:0]) :
		(measure_counter == period_match_value);
	assign count_plus = narrow ? {8'h00, measure_counter[15:0] + 16'h0001} :
		measure_counter + 24'h000001;

	always @* begin
		do_inc = 1'b0;
		do_zero = 1'b0;
		do_one = 1'b0;
		cap_width = 1'b0;
		cap_period = 1'b0;
		done = 1'b0;
		arm_set = 1'b0;
		arm_clr = 1'b0;
		if (active && step) begin
			case (mode)
			`MODE_TIMER: do_inc = 1'b1;
			`MODE_GATED: begin
				do_inc = sig_pol;
				cap_width = s_fall;
				done = s_fall;
			end
			`MODE_DUTY: begin
				do_inc = 1'b1;
				cap_width = s_fall;
				cap_period = s_rise;
				do_one = s_rise;
				done = s_rise;
			end
			`MODE_HILO: begin
				do_inc = armed_reg;
				arm_set = s_rise;
				cap_width = s_fall & armed_reg;
				cap_period = s_rise & seen_fall_reg;
				do_zero = cap_width | cap_period;
				done = cap_period;
			end
			`MODE_WINDOW, `MODE_GATEWIN: begin
				do_inc = armed_reg & (mode == `MODE_WINDOW | sig_pol);
				arm_set = w_rise;
				cap_period = w_rise & armed_reg;
				do_zero = cap_period;
				done = cap_period;
			end
			`MODE_FLIGHT: begin
				do_inc = armed_reg;
				arm_set = w_rise;
				cap_width = w_rise & armed_reg;
				cap_period = s_rise & armed_reg;
				arm_clr = cap_period;
				do_zero = cap_width | cap_period;
				done = cap_period;
			end
			`MODE_CAPTURE: begin
				do_inc = 1'b1;
				cap_period = w_rise;
				cap_width = w_fall;
				done = w_rise;
			end
			`MODE_COUNT, `MODE_GCOUNT: begin
				do_inc = s_rise & (mode == `MODE_COUNT | win_pol);
				cap_width = w_fall;
				done = w_fall;
			end
			`MODE_WCOUNT: begin
				do_inc = s_rise & armed_reg;
				arm_set = w_rise;
				cap_width = w_fall & armed_reg;
				cap_period = w_rise & armed_reg;
				done = cap_period;
			end
			default: ;
			endcase
		end
	end

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign wr_stat = wr_fire && awaddr_reg == `OFF_STAT && wstrb_reg[0];

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sig_sync <= 2'b00;
			win_sync <= 2'b00;
			sig_cur  <= 1'b0;
			win_cur  <= 1'b0;
		end else begin
			sig_sync <= {sig_sync[0], measured_input};
			win_sync <= {win_sync[0], window_input};
			if (step) begin
				sig_cur <= sig_pol;
				win_cur <= win_pol;
			end
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			control_register_zero <= `CON0_RESET;
			control_register_one  <= `CON1_RESET;
			clock_select_register <= `CLKSEL_RESET;
			period_match_value    <= `MATCH_RESET;
			measure_counter       <= 24'h000000;
			pulse_width_latch     <= 24'h000000;
			period_latch          <= 24'h000000;
			run_state             <= 1'b0;
			width_acquired_flag   <= 1'b0;
			period_acquired_flag  <= 1'b0;
			match_flag            <= 1'b0;
			armed_reg             <= 1'b0;
			seen_fall_reg         <= 1'b0;
			aw_held               <= 1'b0;
			w_held                <= 1'b0;
			awaddr_reg            <= 8'h00;
			wdata_reg             <= 32'h00000000;
			wstrb_reg             <= 4'h0;
			s_axi_bvalid          <= 1'b0;
			s_axi_bresp           <= `RESP_OKAY;
		end else begin
			if (step)
				run_state <= control_register_one[`CON1_RUN];
			if (!active) begin
				armed_reg <= 1'b0;
				seen_fall_reg <= 1'b0;
			end else begin
				if (arm_set)
					armed_reg <= 1'b1;
				if (arm_clr)
					armed_reg <= 1'b0;
				if (mode == `MODE_HILO && s_fall && armed_reg)
					seen_fall_reg <= 1'b1;
				if (cap_period)
					seen_fall_reg <= 1'b0;
			end
			if (do_one)
				measure_counter <= 24'h000001;
			else if (do_zero)
				measure_counter <= 24'h000000;
			else if (do_inc && at_match) begin
				// Halted, the counter parks on the match value.
				if (!control_register_zero[`CON0_HALT])
					measure_counter <= 24'h000000;
			end else if (do_inc)
				measure_counter <= count_plus;
			if (done && !control_register_one[`CON1_REPEAT])
				control_register_one[`CON1_RUN] <= 1'b0;
			// Bus handshake, then the register write itself.
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (awaddr_reg == `OFF_CON0) begin
					if (wstrb_reg[0])
						control_register_zero <= wdata_reg[7:0];
				end else if (awaddr_reg == `OFF_CON1) begin
					if (wstrb_reg[0])
						control_register_one <= wdata_reg[7:0];
				end else if (awaddr_reg == `OFF_CLKSEL) begin
					if (wstrb_reg[0])
						clock_select_register <= wdata_reg[2:0];
				end else if (awaddr_reg == `OFF_COUNTER) begin
					// Not atomic across bytes; stop the timer first.
					measure_counter <= merge24(measure_counter, wdata_reg,
						wstrb_reg);
				end else if (awaddr_reg == `OFF_MATCH) begin
					period_match_value <= merge24(period_match_value,
						wdata_reg, wstrb_reg);
				end else if (awaddr_reg != `OFF_STAT &&
					awaddr_reg != `OFF_WIDTH && awaddr_reg != `OFF_PERIOD)
					s_axi_bresp <= `RESP_SLVERR;
			end
			if (wr_stat && wdata_reg[`STAT_CLEAR])
				measure_counter <= 24'h000000;
			if (wr_stat && wdata_reg[`STAT_WIDTH_FLG])
				width_acquired_flag <= 1'b0;
			if (wr_stat && wdata_reg[`STAT_PERIOD_FLG])
				period_acquired_flag <= 1'b0;
			if (wr_stat && wdata_reg[`STAT_MATCH_FLG])
				match_flag <= 1'b0;
			// Sets come last so an event in the clearing cycle wins.
			if (cap_width || (wr_stat && wdata_reg[`STAT_WIDTH_UPD])) begin
				pulse_width_latch <= measure_counter;
				width_acquired_flag <= 1'b1;
			end
			if (cap_period || (wr_stat && wdata_reg[`STAT_PERIOD_UPD])) begin
				period_latch <= measure_counter;
				period_acquired_flag <= 1'b1;
			end
			if (do_inc && at_match)
				match_flag <= 1'b1;
		end
	end

	assign window_level = run_state && (mode == `MODE_WINDOW ||
		mode == `MODE_GCOUNT || mode == `MODE_GATEWIN) && win_cur;
	assign signal_level = run_state && mode != `MODE_WINDOW &&
		mode != `MODE_FLIGHT && mode != `MODE_CAPTURE && sig_cur;
	assign stat_word = ({31'h0, window_level} << `STAT_WIN_LVL) |
		({31'h0, signal_level} << `STAT_SIG_LVL) |
		({31'h0, run_state} << `STAT_RUNNING) |
		({31'h0, width_acquired_flag} << `STAT_WIDTH_FLG) |
		({31'h0, period_acquired_flag} << `STAT_PERIOD_FLG) |
		({31'h0, match_flag} << `STAT_MATCH_FLG);

	always @* begin
		read_resp = `RESP_OKAY;
		if (s_axi_araddr == `OFF_CON0)
			read_word = {24'h000000, control_register_zero};
		else if (s_axi_araddr == `OFF_CON1)
			read_word = {24'h000000, control_register_one};
		else if (s_axi_araddr == `OFF_STAT)
			read_word = stat_word;
		else if (s_axi_araddr == `OFF_CLKSEL)
			read_word = {29'h00000000, clock_select_register};
		else if (s_axi_araddr == `OFF_COUNTER)
			read_word = {8'h00, measure_counter};
		else if (s_axi_araddr == `OFF_WIDTH)
			read_word = {8'h00, pulse_width_latch};
		else if (s_axi_araddr == `OFF_PERIOD)
			read_word = {8'h00, period_latch};
		else if (s_axi_araddr == `OFF_MATCH)
			read_word = {8'h00, period_match_value};
		else begin
			read_word = 32'h00000000;
			read_resp = `RESP_SLVERR;
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word;
			s_axi_rresp  <= read_resp;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // measure_timer

// >>> verif/measure_timer_assertions.sv
// Bus protocol checker for the measurement timer.
// Assumes it is bound to measure_timer and sees only its ports.
`timescale 1ns/100ps
`include "smt_map.vh"
module measure_timer_checker (
	input wire        mclk,
	input wire        resetn,
	input wire [7:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        measured_input,
	input wire        window_input,
	input wire        fast_internal_oscillator,
	input wire        slow_internal_oscillator,
	input wire        mid_internal_oscillator
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("late write answer");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer lost");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken early");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("late read answer");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer lost");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error data not 0");
	property p_top_byte;
		s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00;
	endproperty
	a_top_byte: assert property (p_top_byte) else $error("top byte not 0");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_error: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // measure_timer_checker
bind measure_timer measure_timer_checker i_measure_timer_checker (.mclk,
	.resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.measured_input, .window_input, .fast_internal_oscillator,
	.slow_internal_oscillator, .mid_internal_oscillator);

// >>> verif/signal_source.sv
// Model of the external signal, window and oscillator sources.
// Assumes its tasks are called just after a rising mclk edge.
`timescale 1ns/100ps
module signal_source (
	input  wire mclk,
	output reg  measured_input,
	output reg  window_input,
	output wire fast_internal_oscillator,
	output wire slow_internal_oscillator,
	output wire mid_internal_oscillator
);
	reg [4:0] div_reg = 5'h00;
	// Oscillators run free, slower than half of mclk as the sampler needs.
	always @(posedge mclk) div_reg <= div_reg + 5'h01;
	assign fast_internal_oscillator = div_reg[1];
	assign slow_internal_oscillator = div_reg[3];
	assign mid_internal_oscillator = div_reg[4];
	initial begin
		measured_input = 1'b0;
		window_input = 1'b0;
	end
	task pulse(input integer h, input integer l);
		begin
			measured_input <= 1'b1;
			repeat (h) @(posedge mclk);
			measured_input <= 1'b0;
			repeat (l) @(posedge mclk);
		end
	endtask
	task wpulse(input integer h, input integer l);
		begin
			window_input <= 1'b1;
			repeat (h) @(posedge mclk);
			window_input <= 1'b0;
			repeat (l) @(posedge mclk);
		end
	endtask
	task level(input v);
		begin
			measured_input <= v;
			@(posedge mclk);
		end
	endtask
endmodule // signal_source

// >>> verif/measure_timer_test.sv
// Self-checking bench for the measurement timer.
// Assumes the checker binds itself and the partner drives the pins.
`timescale 1ns/100ps
`include "smt_map.vh"
module measure_timer_test;
	reg         mclk = 1'b0;
	reg         resetn = 1'b0;
	reg  [7:0]  s_axi_awaddr = 8'h00;
	reg         s_axi_awvalid = 1'b0;
	wire        s_axi_awready;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'h0;
	reg         s_axi_wvalid = 1'b0;
	wire        s_axi_wready;
	wire [1:0]  s_axi_bresp;
	wire        s_axi_bvalid;
	reg         s_axi_bready = 1'b0;
	reg  [7:0]  s_axi_araddr = 8'h00;
	reg         s_axi_arvalid = 1'b0;
	wire        s_axi_arready;
	wire [31:0] s_axi_rdata;
	wire [1:0]  s_axi_rresp;
	wire        s_axi_rvalid;
	reg         s_axi_rready = 1'b0;
	wire        measured_input, window_input;
	wire        fast_internal_oscillator, slow_internal_oscillator;
	wire        mid_internal_oscillator;
	integer     bad_count = 0;
	integer     tests_run = 0;
	integer     i;
	integer     sh;
	reg  [31:0] rv;
	reg  [1:0]  br;
	reg  [1:0]  rr;
	always #20 mclk = ~mclk;
	measure_timer i_measure_timer (.mclk, .resetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.measured_input, .window_input, .fast_internal_oscillator,
		.slow_internal_oscillator, .mid_internal_oscillator);
	signal_source i_signal_source (.mclk, .measured_input, .window_input,
		.fast_internal_oscillator, .slow_internal_oscillator,
		.mid_internal_oscillator);
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task hung(input string nm);
		begin
			$display("mismatch %s expected answer seen none", nm);
			bad_count = bad_count + 1;
			report_and_stop;
		end
	endtask
	task rng(input string nm, input [31:0] lo, input [31:0] hi,
		input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if ((g >= lo && g <= hi) !== 1'b1) begin
				$display("mismatch %s expected %h..%h seen %h", nm, lo, hi, g);
				bad_count = bad_count + 1;
			end
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		rng(nm, e, e, g);
	endtask
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		integer n;
		begin
			@(posedge mclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge mclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) begin
					br = s_axi_bresp;
					n = 99;
				end
			end
			s_axi_bready <= 1'b0;
			if (n < 99) hung("bvalid");
		end
	endtask
	task rd(input [7:0] a);
		integer n;
		begin
			@(posedge mclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge mclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) begin
					rv = s_axi_rdata;
					rr = s_axi_rresp;
					n = 99;
				end
			end
			s_axi_rready <= 1'b0;
			if (n < 99) hung("rvalid");
		end
	endtask
	task rchk(input string nm, input [7:0] a, input [31:0] e);
		begin
			rd(a);
			chk(nm, e, rv);
		end
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		rchk("con0", `OFF_CON0, 32'h0);
		rchk("con1", `OFF_CON1, 32'h0);
		rchk("clksel", `OFF_CLKSEL, 32'h0);
		rchk("match", `OFF_MATCH, 32'h00FFFFFF);
		rchk("counter", `OFF_COUNTER, 32'h0);
		wr(8'h20, 32'h1, 4'hF);
		chk("bresp", `RESP_SLVERR, br);
		rchk("unmapped", 8'h20, 32'h0);
		chk("rresp", `RESP_SLVERR, rr);
		wr(`OFF_COUNTER, 32'hFF123456, 4'hF);
		wr(`OFF_COUNTER, 32'h000000AB, 4'h1);
		rchk("counter", `OFF_COUNTER, 32'h001234AB);
		wr(`OFF_STAT, 32'h3, 4'hF);
		rchk("width", `OFF_WIDTH, 32'h001234AB);
		rchk("period", `OFF_PERIOD, 32'h001234AB);
		rd(`OFF_STAT);
		chk("flags", 32'h300, rv & 32'h300);
		wr(`OFF_STAT, 32'h704, 4'hF);
		rchk("counter", `OFF_COUNTER, 32'h0);
		rd(`OFF_STAT);
		chk("flags", 32'h0, rv & 32'h700);
		// Source 0 with every prescale, then sources 1 and 2; the count shrinks by the ratio.
		for (i = 0; i < 6; i = i + 1) begin
			sh = (i < 4) ? i : i - 2;
			wr(`OFF_CON0, {30'h0, i[1:0]}, 4'hF);
			wr(`OFF_CLKSEL, (i < 4) ? 32'h0 : i - 3, 4'hF);
			wr(`OFF_STAT, 32'h4, 4'hF);
			wr(`OFF_CON1, 32'h80, 4'hF);
			repeat (64) @(posedge mclk);
			wr(`OFF_CON1, 32'h0, 4'hF);
			rd(`OFF_COUNTER);
			rng("counter", (64 >> sh) - 2, (72 >> sh) + 2, rv);
		end
		wr(`OFF_CON0, 32'h0, 4'hF);
		wr(`OFF_CLKSEL, 32'h0, 4'hF);
		wr(`OFF_MATCH, 32'h5, 4'hF);
		wr(`OFF_STAT, 32'h704, 4'hF);
		wr(`OFF_CON1, 32'h80, 4'hF);
		i_signal_source.pulse(3, 3);
		rchk("con1", `OFF_CON1, 32'h80);
		rd(`OFF_STAT);
		chk("running", 32'h20, rv & 32'h20);
		repeat (40) @(posedge mclk);
		wr(`OFF_CON1, 32'h0, 4'hF);
		rd(`OFF_COUNTER);
		rng("counter", 32'h0, 32'h5, rv);
		rd(`OFF_STAT);
		chk("match", 32'h400, rv & 32'h400);
		wr(`OFF_CON0, 32'h20, 4'hF);
		wr(`OFF_STAT, 32'h704, 4'hF);
		wr(`OFF_CON1, 32'h80, 4'hF);
		repeat (30) @(posedge mclk);
		wr(`OFF_CON1, 32'h0, 4'hF);
		rchk("halted", `OFF_COUNTER, 32'h5);
		rd(`OFF_STAT);
		chk("match", 32'h400, rv & 32'h400);
		// Match above the longest period keeps the latches meaningful.
		wr(`OFF_CON0, 32'h0, 4'hF);
		wr(`OFF_MATCH, 32'hFFFFFF, 4'hF);
		wr(`OFF_STAT, 32'h704, 4'hF);
		wr(`OFF_CON1, 32'hC2, 4'hF);
		repeat (3) i_signal_source.pulse(6, 10);
		wr(`OFF_CON1, 32'h42, 4'hF);
		rd(`OFF_WIDTH);
		rng("width", 32'h5, 32'h8, rv);
		rd(`OFF_PERIOD);
		rng("period", 32'hF, 32'h12, rv);
		rd(`OFF_STAT);
		chk("flags", 32'h300, rv & 32'h300);
		wr(`OFF_CON1, 32'h82, 4'hF);
		repeat (2) i_signal_source.pulse(6, 10);
		rchk("single", `OFF_CON1, 32'h02);
		wr(`OFF_STAT, 32'h704, 4'hF);
		wr(`OFF_CON1, 32'hC1, 4'hF);
		i_signal_source.pulse(8, 8);
		wr(`OFF_CON1, 32'h41, 4'hF);
		rd(`OFF_WIDTH);
		rng("gated", 32'h7, 32'h9, rv);
		wr(`OFF_CON0, 32'h08, 4'hF);
		wr(`OFF_STAT, 32'h704, 4'hF);
		i_signal_source.level(1'b1);
		wr(`OFF_CON1, 32'hC1, 4'hF);
		repeat (20) @(posedge mclk);
		wr(`OFF_CON1, 32'h41, 4'hF);
		rchk("inverted", `OFF_COUNTER, 32'h0);
		i_signal_source.level(1'b0);
		wr(`OFF_CON1, 32'hC1, 4'hF);
		repeat (20) @(posedge mclk);
		wr(`OFF_CON1, 32'h41, 4'hF);
		rd(`OFF_COUNTER);
		rng("inverted", 32'hF, 32'h1E, rv);
		wr(`OFF_CON0, 32'h40, 4'hF);
		wr(`OFF_COUNTER, 32'h12FFF0, 4'hF);
		wr(`OFF_CON1, 32'hC0, 4'hF);
		repeat (20) @(posedge mclk);
		wr(`OFF_CON1, 32'h40, 4'hF);
		rd(`OFF_COUNTER);
		rng("narrow", 32'h3, 32'hB, rv);
		wr(`OFF_CON0, 32'h0, 4'hF);
		wr(`OFF_STAT, 32'h704, 4'hF);
		wr(`OFF_CON1, 32'hCB, 4'hF);
		repeat (2) i_signal_source.pulse(4, 4);
		wr(`OFF_CON1, 32'h4B, 4'hF);
		rchk("reserved", `OFF_COUNTER, 32'h0);
		rd(`OFF_STAT);
		chk("flags", 32'h0, rv & 32'h300);
		wr(`OFF_CON1, 32'hC7, 4'hF);
		i_signal_source.wpulse(5, 5);
		wr(`OFF_CON1, 32'h47, 4'hF);
		rd(`OFF_PERIOD);
		sh = rv;
		rd(`OFF_WIDTH);
		chk("capture", sh + 5, rv);
		report_and_stop;
	end
endmodule // measure_timer_test
